// file: hdl/rca_top.sv
// Control-location arbiter, analog scaling and log record controller
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// ----------------------------------------
// ----------------------------------------
module rca_top #(
  parameter int unsigned CYC_PER_MS = rca_pkg::CYC_PER_MS
) (
  // Clock, reset, enable
  input  wire logic              clock_in,
  input  wire logic              rst_n_in,
  input  wire logic              clk_en_in,
  // Avalon-MM slave
  input  wire logic [2:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Digital remote port
  input  wire logic              dig_take_in,
  input  wire logic              dig_release_in,
  output logic                   dig_error_out,
  // Analog port
  input  wire logic              analog_remote_n_in,
  input  wire logic              adc_valid_in,
  input  wire logic [14:0]       voltage_setpoint_input_in,
  input  wire logic [14:0]       current_setpoint_input_in,
  input  wire logic [14:0]       power_setpoint_input_in,
  input  wire logic [14:0]       resistance_setpoint_input_in,
  output logic [14:0]            reference_out,
  output logic [14:0]            voltage_monitor_output_out,
  output logic [14:0]            current_monitor_output_out,
  // Device state
  input  wire logic              dc_output_on_in,
  input  wire logic [1:0]        regulation_mode_in,
  input  wire logic [3:0]        alarm_code_in,
  input  wire logic [13:0]       meas_v_in,
  input  wire logic [13:0]       meas_i_in,
  input  wire logic [13:0]       meas_p_in,
  input  wire logic [13:0]       meas_r_in,
  output rca_pkg::rca_loc_t      loc_out,
  output logic                   local_lock_out,
  output logic [13:0]            set_v_out,
  output logic [13:0]            set_i_out,
  output logic [13:0]            set_p_out,
  output logic [13:0]            set_r_out,
  // Log storage
  input  wire logic              media_present_in,
  input  wire logic              media_full_in,
  input  wire logic [10:0]       media_max_file_in,
  input  wire logic              log_ready_in,
  output rca_pkg::rca_log_t      log_state_out,
  output logic                   log_open_out,
  output logic                   log_close_out,
  output logic [10:0]            log_file_no_out,
  output logic                   log_field_valid_out,
  output logic [3:0]             log_field_idx_out,
  output logic [31:0]            log_field_data_out
);
  import rca_pkg::*;

  rca_state_t  s_reg;
  rca_state_t  s_next;
  logic        bus_req;
  logic        wr_go;
  logic        cmd_start;
  logic        cmd_stop;
  logic        start_go;
  logic        stop_go;
  logic        out_rise;
  logic        out_fall;
  logic        ms_tick;
  logic        due;
  logic        media_bad;
  logic [10:0] num;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [13:0] scale_in(input logic [14:0] c, input logic r10);
    if (r10) begin
      scale_in = (c >= IN_FS_10V) ? SP_MAX : c[13:0];
    end else begin
      scale_in = (c >= IN_FS_5V) ? SP_MAX : {c[12:0], 1'b0};
    end
  endfunction : scale_in

  function automatic logic [14:0] scale_out(input logic [13:0] m, input logic r10);
    scale_out = r10 ? {1'b0, m} : {2'b00, m[13:1]};
  endfunction : scale_out

  function automatic logic [31:0] field_val(input logic [3:0] k, input rca_state_t st);
    field_val = 32'h0000_0000;
    unique case (k)
      4'h0: field_val = {18'h0_0000, st.set_v};
      4'h1: field_val = {18'h0_0000, meas_v_in};
      4'h2: field_val = {18'h0_0000, st.set_i};
      4'h3: field_val = {18'h0_0000, meas_i_in};
      4'h4: field_val = {18'h0_0000, st.set_p};
      4'h5: field_val = {18'h0_0000, meas_p_in};
      4'h6: field_val = st.ir_mode ? {18'h0_0000, st.set_r} : NOT_APPL;
      4'h7: field_val = st.ir_mode ? {18'h0_0000, meas_r_in} : NOT_APPL;
      4'h8: field_val = {31'h0000_0000, st.ir_mode};
      4'h9: field_val = {31'h0000_0000, dc_output_on_in};
      4'hA: field_val = {30'h0000_0000, regulation_mode_in};
      4'hB: field_val = {28'h000_0000, alarm_code_in};
      4'hC: field_val = st.elapsed_ms;
      default: field_val = 32'h0000_0000;
    endcase
  endfunction : field_val

  function automatic logic [31:0] read_mux(input logic [2:0] a, input rca_state_t st);
    read_mux = 32'h0000_0000;
    unique case (a)
      REG_CTRL: begin
        read_mux[CTRL_ALLOW]   = st.allow_remote;
        read_mux[CTRL_RANGE10] = st.range_10v;
        read_mux[CTRL_COUPLED] = st.log_coupled;
        read_mux[CTRL_IRMODE]  = st.ir_mode;
      end
      REG_STATUS: begin
        read_mux[1:0] = st.loc;
        read_mux[STAT_LOG_LSB +: 2] = st.log_state;
        read_mux[STAT_REC] = st.field_valid;
        read_mux[STAT_FILE +: 11] = st.file_no;
      end
      REG_SET_VI: begin
        read_mux[13:0] = st.set_v;
        read_mux[SET_HI_LSB +: 14] = st.set_i;
      end
      REG_SET_PR: begin
        read_mux[13:0] = st.set_p;
        read_mux[SET_HI_LSB +: 14] = st.set_r;
      end
      REG_INTERVAL: read_mux[15:0] = st.intv_ms;
      REG_ELAPSED: read_mux = st.elapsed_ms;
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction : read_mux

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    bus_req = avs_read_in | avs_write_in;
    wr_go = avs_write_in & ~s_reg.waitreq;
    cmd_start = 1'b0;
    cmd_stop = 1'b0;
    s_next.dig_err = 1'b0;
    s_next.log_open = 1'b0;
    s_next.log_close = 1'b0;
    s_next.out_prev = dc_output_on_in;
    out_rise = dc_output_on_in & ~s_reg.out_prev;
    out_fall = ~dc_output_on_in & s_reg.out_prev;
    media_bad = ~media_present_in | media_full_in;

    // Bus slave: one wait cycle, then the answer
    s_next.waitreq = ~(bus_req & s_reg.waitreq);
    if (avs_read_in & s_reg.waitreq) begin
      s_next.rdata = read_mux(avs_address_in, s_reg);
    end
    if (wr_go) begin
      unique case (avs_address_in)
        REG_CTRL: begin
          s_next.allow_remote = avs_writedata_in[CTRL_ALLOW];
          s_next.range_10v = avs_writedata_in[CTRL_RANGE10];
          s_next.log_coupled = avs_writedata_in[CTRL_COUPLED];
          s_next.ir_mode = avs_writedata_in[CTRL_IRMODE];
          cmd_start = avs_writedata_in[CTRL_START];
          cmd_stop = avs_writedata_in[CTRL_STOP];
        end
        REG_SET_VI: begin
          if (s_reg.loc != LOC_ANALOG) begin
            s_next.set_v = avs_writedata_in[13:0];
            s_next.set_i = avs_writedata_in[SET_HI_LSB +: 14];
          end
        end
        REG_SET_PR: begin
          if (s_reg.loc != LOC_ANALOG) begin
            s_next.set_p = avs_writedata_in[13:0];
            s_next.set_r = avs_writedata_in[SET_HI_LSB +: 14];
          end
        end
        REG_INTERVAL: s_next.intv_ms = avs_writedata_in[15:0];
        default: ;
      endcase
    end

    // Control location arbiter
    unique case (s_reg.loc)
      LOC_MANUAL: begin
        if (!s_reg.allow_remote) begin
          s_next.loc = LOC_LOCAL;
        end else if (!analog_remote_n_in) begin
          s_next.loc = LOC_ANALOG;
        end else if (dig_take_in) begin
          s_next.loc = LOC_DIGITAL;
        end
        s_next.dig_err = dig_take_in & ~analog_remote_n_in;
      end
      LOC_ANALOG: begin
        if (!s_reg.allow_remote) begin
          s_next.loc = LOC_LOCAL;
        end else if (analog_remote_n_in) begin
          s_next.loc = LOC_MANUAL;
        end
        s_next.dig_err = dig_take_in;
      end
      LOC_DIGITAL: begin
        if (!s_reg.allow_remote) begin
          s_next.loc = LOC_LOCAL;
        end else if (dig_release_in) begin
          s_next.loc = LOC_MANUAL;
        end
      end
      LOC_LOCAL: begin
        if (s_reg.allow_remote) begin
          s_next.loc = analog_remote_n_in ? LOC_MANUAL : LOC_ANALOG;
        end
        s_next.dig_err = dig_take_in;
      end
    endcase

    s_next.lock = (s_next.loc == LOC_LOCAL);
    // Analog setpoints, applied only on fresh samples
    if ((s_reg.loc == LOC_ANALOG) && adc_valid_in) begin
      s_next.set_v = scale_in(voltage_setpoint_input_in, s_reg.range_10v);
      s_next.set_i = scale_in(current_setpoint_input_in, s_reg.range_10v);
      s_next.set_p = scale_in(power_setpoint_input_in, s_reg.range_10v);
      if (s_reg.ir_mode) begin
        s_next.set_r = scale_in(resistance_setpoint_input_in, s_reg.range_10v);
      end
    end
    s_next.ref_code = s_reg.range_10v ? REF_10V : REF_5V;
    s_next.mon_v = scale_out(meas_v_in, s_reg.range_10v);
    s_next.mon_i = scale_out(meas_i_in, s_reg.range_10v);

    // Start and stop sources
    if (s_reg.log_coupled) begin
      start_go = out_rise;
      stop_go = out_fall;
    end else begin
      start_go = cmd_start;
      stop_go = cmd_stop;
    end
    if (media_max_file_in >= s_reg.next_no) begin
      num = 11'(media_max_file_in + 11'h001);
    end else begin
      num = s_reg.next_no;
    end
    ms_tick = (s_reg.ms_div == 17'(CYC_PER_MS - 1));
    due = 1'b0;

    // Log session
    unique case (s_reg.log_state)
      LOG_IDLE, LOG_FAULT: begin
        if (start_go) begin
          if (media_bad || (num > MAX_FILES)) begin
            s_next.log_state = LOG_FAULT;
          end else begin
            s_next.log_state = LOG_RUN;
            s_next.log_open = 1'b1;
            s_next.file_no = num;
            s_next.next_no = 11'(num + 11'h001);
            s_next.file_bytes = 33'h0_0000_0000;
            s_next.elapsed_ms = 32'h0000_0000;
            s_next.ms_div = 17'h0_0000;
            s_next.intv_cnt = 16'h0000;
            s_next.field_idx = 4'h0;
            s_next.field_valid = 1'b0;
          end
        end
      end
      LOG_RUN: begin
        if (stop_go) begin
          s_next.log_state = LOG_IDLE;
          s_next.log_close = 1'b1;
          s_next.field_valid = 1'b0;
        end else if (media_bad) begin
          s_next.log_state = LOG_FAULT;
          s_next.log_close = 1'b1;
          s_next.field_valid = 1'b0;
        end else begin
          s_next.ms_div = ms_tick ? 17'h0_0000 : 17'(s_reg.ms_div + 17'h0_0001);
          if (ms_tick) begin
            s_next.elapsed_ms = s_reg.elapsed_ms + 32'h0000_0001;
            if (17'(s_reg.intv_cnt) + 17'h0_0001 >= 17'(s_reg.intv_ms)) begin
              s_next.intv_cnt = 16'h0000;
              due = 1'b1;
            end else begin
              s_next.intv_cnt = s_reg.intv_cnt + 16'h0001;
            end
          end
          if (s_reg.field_valid && log_ready_in) begin
            s_next.file_bytes = s_reg.file_bytes + FLD_BYTES;
            if (s_reg.field_idx == LAST_FLD) begin
              s_next.field_valid = 1'b0;
            end else begin
              s_next.field_idx = s_reg.field_idx + 4'h1;
              s_next.field_data = field_val(s_reg.field_idx + 4'h1, s_reg);
            end
          end else if (due && !s_reg.field_valid) begin
            if (s_reg.file_bytes > FILE_LIMIT - REC_BYTES) begin
              s_next.log_state = LOG_FAULT;
              s_next.log_close = 1'b1;
            end else begin
              s_next.field_valid = 1'b1;
              s_next.field_idx = 4'h0;
              s_next.field_data = field_val(4'h0, s_reg);
            end
          end
        end
      end
      default: begin
        s_next.log_state = LOG_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
      s_reg.loc <= LOC_MANUAL;
      s_reg.log_state <= LOG_IDLE;
      s_reg.allow_remote <= ALLOW_RST;
      s_reg.range_10v <= RANGE10_RST;
      s_reg.ref_code <= REF_10V;
      s_reg.waitreq <= 1'b1;
      s_reg.next_no <= FIRST_FILE;
      s_reg.intv_ms <= INTERVAL_RST;
    end else if (clk_en_in) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata_out           = s_reg.rdata;
  assign avs_waitrequest_out        = s_reg.waitreq;
  assign dig_error_out              = s_reg.dig_err;
  assign reference_out              = s_reg.ref_code;
  assign voltage_monitor_output_out = s_reg.mon_v;
  assign current_monitor_output_out = s_reg.mon_i;
  assign loc_out                    = s_reg.loc;
  assign local_lock_out             = s_reg.lock;
  assign set_v_out                  = s_reg.set_v;
  assign set_i_out                  = s_reg.set_i;
  assign set_p_out                  = s_reg.set_p;
  assign set_r_out                  = s_reg.set_r;
  assign log_state_out              = s_reg.log_state;
  assign log_open_out               = s_reg.log_open;
  assign log_close_out              = s_reg.log_close;
  assign log_file_no_out            = s_reg.file_no;
  assign log_field_valid_out        = s_reg.field_valid;
  assign log_field_idx_out          = s_reg.field_idx;
  assign log_field_data_out         = s_reg.field_data;

endmodule : rca_top

// file: common/rca_pkg.sv
// Constants and state type of the remote control arbiter and logger
package rca_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 32'h0000_000A;
  localparam int unsigned MS_NS         = 32'h000F_4240;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Register word addresses
  // ----------------------------------------
  localparam logic [2:0] REG_CTRL     = 3'h0;
  localparam logic [2:0] REG_STATUS   = 3'h1;
  localparam logic [2:0] REG_SET_VI   = 3'h2;
  localparam logic [2:0] REG_SET_PR   = 3'h3;
  localparam logic [2:0] REG_INTERVAL = 3'h4;
  localparam logic [2:0] REG_ELAPSED  = 3'h5;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_ALLOW   = 0;
  localparam int CTRL_RANGE10 = 1;
  localparam int CTRL_COUPLED = 2;
  localparam int CTRL_IRMODE  = 3;
  localparam int CTRL_START   = 8;
  localparam int CTRL_STOP    = 9;
  localparam int SET_HI_LSB   = 16;
  localparam int STAT_LOG_LSB = 2;
  localparam int STAT_REC     = 4;
  localparam int STAT_FILE    = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic        ALLOW_RST    = 1'h1;
  localparam logic        RANGE10_RST  = 1'h1;
  localparam logic [10:0] FIRST_FILE   = 11'h001;
  localparam logic [15:0] INTERVAL_RST = 16'h03E8;

  // ----------------------------------------
  // Scaling, limits, record layout
  // ----------------------------------------
  localparam logic [13:0] SP_MAX     = 14'h3FFF;
  localparam logic [14:0] IN_FS_10V  = 15'h3FFF;
  localparam logic [14:0] IN_FS_5V   = 15'h2000;
  localparam logic [14:0] REF_10V    = 15'h4000;
  localparam logic [14:0] REF_5V     = 15'h2000;
  localparam logic [10:0] MAX_FILES  = 11'h400;
  localparam logic [32:0] FILE_LIMIT = 33'h1_0000_0000;
  localparam logic [32:0] REC_BYTES  = 33'h0_0000_0034;
  localparam logic [32:0] FLD_BYTES  = 33'h0_0000_0004;
  localparam logic [3:0]  LAST_FLD   = 4'hC;
  localparam logic [31:0] NOT_APPL   = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {LOC_MANUAL, LOC_ANALOG, LOC_DIGITAL, LOC_LOCAL} rca_loc_t;
  typedef enum logic [1:0] {LOG_IDLE, LOG_RUN, LOG_FAULT} rca_log_t;

  typedef struct packed {
    rca_loc_t    loc;
    logic        lock;
    rca_log_t    log_state;
    logic        allow_remote;
    logic        range_10v;
    logic        log_coupled;
    logic        ir_mode;
    logic [13:0] set_v;
    logic [13:0] set_i;
    logic [13:0] set_p;
    logic [13:0] set_r;
    logic [14:0] ref_code;
    logic [14:0] mon_v;
    logic [14:0] mon_i;
    logic        dig_err;
    logic        log_open;
    logic        log_close;
    logic        out_prev;
    logic        waitreq;
    logic        field_valid;
    logic [10:0] file_no;
    logic [10:0] next_no;
    logic [32:0] file_bytes;
    logic [16:0] ms_div;
    logic [31:0] elapsed_ms;
    logic [15:0] intv_ms;
    logic [15:0] intv_cnt;
    logic [3:0]  field_idx;
    logic [31:0] field_data;
    logic [31:0] rdata;
  } rca_state_t;

endpackage : rca_pkg

// file: verification/rca_sva.sv
// Concurrent checks on the ports of the remote control arbiter and logger
`timescale 1ns/1ps
module rca_sva (
  // Clock and reset
  input wire logic                clock_in,
  input wire logic                rst_n_in,
  input wire logic                clk_en_in,
  // Bus and digital port
  input wire logic                avs_read_in,
  input wire logic                avs_write_in,
  input wire logic                avs_waitrequest_out,
  input wire logic                dig_take_in,
  input wire logic                dig_release_in,
  input wire logic                dig_error_out,
  // Analog port and location
  input wire logic [13:0]         meas_v_in,
  input wire logic [14:0]         reference_out,
  input wire logic [14:0]         voltage_monitor_output_out,
  input wire rca_pkg::rca_loc_t   loc_out,
  input wire logic                local_lock_out,
  input wire logic [13:0]         set_v_out,
  input wire logic [13:0]         set_i_out,
  // Logging
  input wire logic                log_ready_in,
  input wire rca_pkg::rca_log_t   log_state_out,
  input wire logic                log_open_out,
  input wire logic                log_close_out,
  input wire logic [10:0]         log_file_no_out,
  input wire logic                log_field_valid_out,
  input wire logic [3:0]          log_field_idx_out
);
  import rca_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  property p_reset; $rose(rst_n_in) |-> loc_out == LOC_MANUAL && log_state_out == LOG_IDLE; endproperty
  a_reset: assert property (p_reset) else $error("state after reset wrong");
  property p_mon;
    clk_en_in |=> voltage_monitor_output_out ==
      ((reference_out == REF_10V) ? {1'b0, $past(meas_v_in)} : ({1'b0, $past(meas_v_in)} >> 1));
  endproperty
  a_mon: assert property (p_mon) else $error("monitor scaling wrong");
  property p_refuse;
    clk_en_in && dig_take_in && loc_out == LOC_ANALOG && !avs_write_in && !$past(avs_write_in)
      |=> dig_error_out && loc_out != LOC_DIGITAL;
  endproperty
  a_refuse: assert property (p_refuse) else $error("digital take not refused");
  property p_err_cause; dig_error_out |-> $past(dig_take_in); endproperty
  a_err_cause: assert property (p_err_cause) else $error("error without take");
  property p_ignore;
    clk_en_in && loc_out == LOC_DIGITAL && !dig_release_in && !avs_write_in && !$past(avs_write_in)
      |=> loc_out == LOC_DIGITAL;
  endproperty
  a_ignore: assert property (p_ignore) else $error("digital control lost");
  property p_lock; local_lock_out == (loc_out == LOC_LOCAL); endproperty
  a_lock: assert property (p_lock) else $error("lock flag mismatch");
  property p_wait;
    clk_en_in && (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer timing wrong");
  property p_open; log_open_out |-> log_state_out == LOG_RUN && log_file_no_out != 11'h000 && log_file_no_out <= MAX_FILES; endproperty
  a_open: assert property (p_open) else $error("open without valid session");
  property p_close; log_close_out |-> log_state_out != LOG_RUN; endproperty
  a_close: assert property (p_close) else $error("close while running");
  property p_field;
    clk_en_in && log_field_valid_out && log_ready_in && log_field_idx_out != LAST_FLD
      |=> (log_field_valid_out && log_field_idx_out == $past(log_field_idx_out) + 4'h1) || log_state_out != LOG_RUN;
  endproperty
  a_field: assert property (p_field) else $error("field order broken");
  property p_keep; loc_out != LOC_ANALOG ##1 loc_out == LOC_ANALOG |-> $stable(set_v_out) && $stable(set_i_out); endproperty
  a_keep: assert property (p_keep) else $error("setpoints changed on entry");
endmodule : rca_sva

// file: verification/rca_host.sv
// Far side model: analog controller and log storage sink
`timescale 1ns/1ps
module rca_host (
  input wire logic         clock_in,
  input wire logic         stall_in,
  input wire logic         go_in,
  input wire logic [14:0]  code_in,
  input wire logic         field_valid_in,
  input wire logic [3:0]   field_idx_in,
  input wire logic [31:0]  field_data_in,
  output logic             ready_out = 1'b1,
  output logic             adc_valid_out = 1'b0,
  output logic [14:0]      sample_out = 15'h0000,
  output logic [31:0]      rec_out [13],
  output int               recs_out = 0
);
  always @(posedge clock_in) begin
    ready_out     <= !stall_in || !ready_out;
    adc_valid_out <= go_in;
    sample_out    <= go_in ? code_in : ~sample_out;
    if (field_valid_in && ready_out) begin
      rec_out[field_idx_in] <= field_data_in;
      if (field_idx_in == 4'hC) recs_out <= recs_out + 1;
    end
  end
endmodule : rca_host

// file: verification/tb_rca_top.sv
// Self-checking testbench of the remote control arbiter and logger
`timescale 1ns/1ps
module tb_rca_top;
  import rca_pkg::*;
  logic        clock_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0, dig_take_in = 0, go = 0, stall = 0;
  logic        analog_remote_n_in = 1, dc_output_on_in = 0, media_full_in = 0, adc_valid, log_ready;
  logic        avs_waitrequest_out, dig_error_out, local_lock_out, log_open_out, log_close_out, log_field_valid_out;
  logic [2:0]  avs_address_in = 0;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out, log_field_data_out, q, exp;
  logic [14:0] code = 0, sample, reference_out, voltage_monitor_output, imon;
  logic [13:0] meas_v = 0, meas_i = 0, set_v_out, set_i_out, set_p_out, set_r_out;
  logic [3:0]  alarm = 0, log_field_idx_out;
  logic [10:0] media_max = 0, log_file_no_out;
  logic [31:0] rec [13];
  rca_loc_t    loc_out;
  rca_log_t    log_state_out;
  int          fails = 0, checks_done = 0, recs, nxt = 1, fno;
  rca_top #(.CYC_PER_MS(10)) i_rca_top (.*, .clk_en_in(1'b1), .dig_release_in(1'b0), .adc_valid_in(adc_valid),
    .voltage_setpoint_input_in(sample), .current_setpoint_input_in(sample), .power_setpoint_input_in(sample),
    .resistance_setpoint_input_in(sample), .voltage_monitor_output_out(voltage_monitor_output), .current_monitor_output_out(imon),
    .regulation_mode_in(alarm[1:0]), .alarm_code_in(alarm), .meas_v_in(meas_v), .meas_i_in(meas_i),
    .meas_p_in(meas_i), .meas_r_in(meas_v), .media_present_in(1'b1), .media_max_file_in(media_max),
    .log_ready_in(log_ready));
  rca_host i_rca_host (.clock_in(clock_in), .stall_in(stall), .go_in(go), .code_in(code),
    .field_valid_in(log_field_valid_out), .field_idx_in(log_field_idx_out), .field_data_in(log_field_data_out),
    .ready_out(log_ready), .adc_valid_out(adc_valid), .sample_out(sample), .rec_out(rec), .recs_out(recs));
  initial forever #5 clock_in = ~clock_in;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks_done++;
    if (seen !== ex) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int k = 0;
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    do begin
      @(posedge clock_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 50);
    if (k == 50) fails++;
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    tick(1);
  endtask : bus
  task automatic take;
    dig_take_in <= 1'b1;
    tick(1);
    dig_take_in <= 1'b0;
    tick(1);
  endtask : take
  task automatic start_model;
    fno = (nxt > media_max + 1) ? nxt : media_max + 1;
    nxt = fno + 1;
  endtask : start_model
  task automatic wait_recs(input int n);
    int k = 0;
    while (recs < n && k < 2000) begin
      tick(1);
      k++;
    end
    if (k == 2000) fails++;
  endtask : wait_recs
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    #200000;
    fails++;
    results();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(25));
    tick(10);
    rst_n_in <= 1'b1;
    tick(1);
    chk("loc", loc_out, LOC_MANUAL);
    chk("log", log_state_out, LOG_IDLE);
    chk("ref", reference_out, REF_10V);
    bus(0, REG_CTRL, 0);
    chk("ctrl", q, 32'h0000_0003);
    bus(0, 3'h6, 0);
    chk("unmapped", q, 32'h0000_0000);
    $display("reset test done");
    bus(1, REG_SET_VI, 32'h0155_0123);
    bus(1, REG_SET_PR, 32'h0033_0044);
    take();
    chk("loc", loc_out, LOC_DIGITAL);
    analog_remote_n_in <= 1'b0;
    tick(3);
    chk("loc", loc_out, LOC_DIGITAL);
    bus(0, REG_STATUS, 0);
    chk("status", q[1:0], 32'h0000_0002);
    bus(1, REG_CTRL, 32'h0000_0002);
    tick(2);
    chk("loc", loc_out, LOC_LOCAL);
    chk("lock", local_lock_out, 1);
    bus(1, REG_CTRL, 32'h0000_0003);
    tick(2);
    chk("loc", loc_out, LOC_ANALOG);
    chk("set_v", set_v_out, 32'h0000_0123);
    take();
    chk("error", dig_error_out, 1);
    chk("loc", loc_out, LOC_ANALOG);
    $display("location test done");
    for (int r = 0; r < 2; r++) begin
      bus(1, REG_CTRL, r ? 32'h0000_0001 : 32'h0000_0003);
      tick(2);
      chk("ref", reference_out, r ? REF_5V : REF_10V);
      for (int k = 0; k < 6; k++) begin
        code <= (k == 0) ? 15'h7FFF : (k == 1) ? 15'h2000 : 15'($urandom);
        meas_v <= 14'($urandom);
        meas_i <= 14'($urandom);
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(3);
        exp = r ? ((code >= 15'h2000) ? 32'h3FFF : 32'(code) * 2) : ((code > 15'h3FFF) ? 32'h3FFF : 32'(code));
        chk("set_v", set_v_out, exp);
        chk("set_i", set_i_out, exp);
        chk("set_p", set_p_out, exp);
        chk("voltage_monitor_output", voltage_monitor_output, r ? 32'(meas_v >> 1) : 32'(meas_v));
        chk("imon", imon, r ? 32'(meas_i >> 1) : 32'(meas_i));
      end
    end
    bus(1, REG_SET_VI, 32'h0000_0000);
    chk("set_v", set_v_out, exp);
    $display("analog test done");
    analog_remote_n_in <= 1'b1;
    media_max <= 11'h005;
    alarm <= 4'($urandom);
    tick(2);
    bus(1, REG_SET_PR, 32'h0033_0044);
    bus(1, REG_INTERVAL, 32'h0000_0001);
    bus(1, REG_CTRL, 32'h0000_0007);
    stall <= 1'b1;
    dc_output_on_in <= 1'b1;
    tick(3);
    start_model();
    chk("file", log_file_no_out, fno);
    chk("log", log_state_out, LOG_RUN);
    wait_recs(1);
    chk("f0", rec[0], exp);
    chk("f1", rec[1], 32'(meas_v));
    chk("f6", rec[6], NOT_APPL);
    chk("f7", rec[7], NOT_APPL);
    chk("f9", rec[9], 32'h0000_0001);
    chk("f11", rec[11], 32'(alarm));
    dc_output_on_in <= 1'b0;
    tick(3);
    chk("log", log_state_out, LOG_IDLE);
    bus(1, REG_CTRL, 32'h0000_000B);
    bus(1, REG_CTRL, 32'h0000_010B);
    tick(2);
    start_model();
    chk("file", log_file_no_out, fno);
    dc_output_on_in <= 1'b1;
    tick(3);
    dc_output_on_in <= 1'b0;
    alarm <= 4'hA;
    tick(3);
    chk("log", log_state_out, LOG_RUN);
    wait_recs(recs + 2);
    chk("f6", rec[6], 32'h0000_0033);
    chk("f8", rec[8], 32'h0000_0001);
    bus(1, REG_CTRL, 32'h0000_020B);
    tick(2);
    chk("log", log_state_out, LOG_IDLE);
    media_full_in <= 1'b1;
    bus(1, REG_CTRL, 32'h0000_0103);
    tick(2);
    chk("log", log_state_out, LOG_FAULT);
    media_full_in <= 1'b0;
    media_max <= MAX_FILES;
    bus(1, REG_CTRL, 32'h0000_0103);
    tick(2);
    chk("log", log_state_out, LOG_FAULT);
    $display("logging test done");
    results();
  end
endmodule : tb_rca_top
bind rca_top rca_sva i_rca_sva (.*);
